// ---- flash_addr_pkg.sv ----
package flash_addr_pkg;

  localparam logic [11:0] area_select_offset   = 12'h020;
  localparam logic [11:0] start_address_offset = 12'h030;
  localparam logic [11:0] end_address_offset   = 12'h034;
  localparam logic [11:0] command_offset       = 12'h040;
  localparam logic [11:0] control_offset       = 12'h044;
  localparam logic [11:0] result_offset        = 12'h048;

  localparam logic [7:0]  area_key_value       = 8'h3b;
  localparam int          key_msb              = 15;
  localparam int          key_lsb              = 8;
  localparam int          boot_bit_pos         = 1;
  localparam logic [3:0]  lanes_low_half       = 4'h3;
  localparam logic [3:0]  lanes_word           = 4'hf;

  localparam int          code_addr_msb        = 27;
  localparam int          data_addr_msb        = 20;
  localparam int          compare_msb          = 27;
  localparam int          parity_msb           = 27;
  localparam int          parity_lsb           = 4;

  localparam logic [31:0] boot_area_base       = 32'h0800_0000;
  localparam logic [31:0] boot_area_limit      = 32'h0801_0000;
  localparam logic [31:0] region_size_48k      = 32'h0000_c000;
  localparam logic [31:0] region_bank2_base    = 32'h0018_0000;

  localparam int          align_program_code   = 512;
  localparam int          align_word           = 4;
  localparam int          align_multi_base     = 8;
  localparam int          align_erase_data     = 64;
  localparam int          align_block_small    = 16384;
  localparam int          align_block_large    = 65536;
  localparam int          align_setting_wide   = 32;

  typedef enum logic [3:0] {
    cmd_program_code  = 4'h0,
    cmd_program_data  = 4'h1,
    cmd_multi_program = 4'h2,
    cmd_dma_program   = 4'h3,
    cmd_block_erase   = 4'h4,
    cmd_area_erase    = 4'h5,
    cmd_blank_check   = 4'h6,
    cmd_config_set    = 4'h7,
    cmd_protect_set   = 4'h8,
    cmd_security_set  = 4'h9,
    cmd_status_clear  = 4'ha,
    cmd_forced_stop   = 4'hb,
    cmd_suspend       = 4'hc,
    cmd_resume        = 4'hd
  } command_type;

  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_check = 2'b01,
    st_busy  = 2'b11,
    st_lock  = 2'b10
  } state_type;

  typedef struct packed {
    logic [1:0] multi_size;
    logic       setting_wide;
    logic       erase_block_64k;
  } command_option_type;

  localparam logic [7:0] busy_cycles = 8'h08;

endpackage : flash_addr_pkg

// ---- flash_command_address_setup.sv ----
// How it works
// (R1) Area select clears on reset and init
// (R2) Boot bit changes only with key 3b
// (R3) Key field not stored, reads zero
// (R4) Boot bit writable in serial or break
// (R5) Address registers writable only when ready
// (R6) Bit 1 chooses boot area; reserved zero
// (R7) Wrong area for command flags access error
// (R8) Start address register feeds listed commands
// (R9) High bits masked per flash type
// (R10) Low bits masked below command boundary
// (R11) Erase start aligned per area
// (R12) Setting commands aligned to 4 or 32
// (R13) Bits 27 to 4 make parity
// (R14) Area erase start above end locks
// (R15) Blank check direction ordering check locks
// (R16) Range crossing data region locks
// (R17) 48k regions alternate below 18_0000; one region above
// (R18) Erase end ignores 31:21 and 5:0; the start-above-end check still compares end bits 27:0
// (R19) Blank end ignores 31:21 and 1:0
// (R20) Software keeps bits 27:21 equal
// (R21) Address registers clear on reset and init
// (R22) Area select 16-bit, addresses 32-bit access
// (R23) Clear, stop, suspend, resume ignore address
// (R24) Checks before array work; failure starts none
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
module flash_command_address_setup
  import flash_addr_pkg::*;
#(
  parameter int busy_length = 8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_mode,
  input  wire logic        debug_break,
  output logic             sequencer_ready_flag,
  output logic             code_access_error_flag,
  output logic             command_lock,
  output logic             array_start,
  output logic [31:0]      array_address,
  output logic             address_parity
);

  logic [1:0]         serial_sync;
  logic [1:0]         break_sync;
  logic               boot_area_select_bit;
  logic [31:0]        command_start_address;
  logic [31:0]        command_end_address;
  logic               blank_check_direction;
  logic               target_data;
  command_option_type option;
  command_type        command;
  state_type          state;
  logic [7:0]         busy_count;
  logic               sequencer_init_bit;
  logic               issue;
  logic               write_phase;
  logic               read_phase;
  logic [31:0]        next_address;
  logic               next_error;
  logic               next_lock;
  logic [31:0]        masked_start;
  logic [31:0]        masked_end;
  logic               in_boot;
  logic               commit;
  logic               area_write;
  logic               start_write;
  logic               end_write;

  // Mode pins come from another domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_sync <= 2'b00;
      break_sync  <= 2'b00;
    end else begin
      serial_sync <= {serial_sync[0], serial_mode};
      break_sync  <= {break_sync[0], debug_break};
    end
  end

  assign write_phase = psel && penable && pwrite;
  assign read_phase  = psel && !penable && !pwrite;

  function automatic logic lanes_ok(input logic [11:0] addr, input logic [3:0] strb);
    if (addr == area_select_offset) begin
      lanes_ok = (strb == lanes_low_half); // see (R22)
    end else begin
      lanes_ok = (strb == lanes_word); // see (R22)
    end
  endfunction : lanes_ok

  function automatic logic [31:0] align(input logic [31:0] addr, input int bytes);
    align = addr & ~(32'(bytes) - 32'h1);
  endfunction : align

  function automatic logic [1:0] region_of(input logic [31:0] addr);
    logic [31:0] a;
    a = {11'h000, addr[data_addr_msb:0]};
    if (a >= region_bank2_base) begin
      region_of = 2'h2; // see (R17)
    end else if ((a % (region_size_48k * 2)) >= region_size_48k) begin
      region_of = 2'h1; // see (R17)
    end else begin
      region_of = 2'h0;
    end
  endfunction : region_of

  // A range must stay inside one data region
  function automatic logic crosses(input logic [31:0] first, input logic [31:0] last);
    crosses = (region_of(first) != region_of(last)); // see (R16)
  endfunction : crosses

  function automatic logic mapped(input logic [11:0] addr);
    mapped = addr inside {area_select_offset, start_address_offset, end_address_offset,
                          command_offset, control_offset, result_offset};
  endfunction : mapped

  function automatic logic sized_register(input logic [11:0] addr);
    sized_register = (addr == area_select_offset) || (addr == start_address_offset)
                     || (addr == end_address_offset);
  endfunction : sized_register

  // Writes during setup commit at access with ready high
  assign sequencer_init_bit = write_phase && pready && (paddr == control_offset) && pwdata[0];
  assign issue = write_phase && pready && (paddr == command_offset) && (state == st_idle);

  // Busy sequencer silently drops address writes
  assign commit      = write_phase && pready;
  assign area_write  = commit && (paddr == area_select_offset)
                       && lanes_ok(paddr, pstrb) && sequencer_ready_flag; // see (R5) (R22)
  assign start_write = commit && (paddr == start_address_offset)
                       && lanes_ok(paddr, pstrb) && sequencer_ready_flag; // see (R5) (R22)
  assign end_write   = commit && (paddr == end_address_offset)
                       && lanes_ok(paddr, pstrb) && sequencer_ready_flag; // see (R5) (R22)

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_area_select_bit <= 1'b0; // see (R1)
    end else if (sequencer_init_bit) begin
      boot_area_select_bit <= 1'b0; // see (R1)
    end else if (area_write
                 && pwdata[key_msb:key_lsb] == area_key_value
                 && (serial_sync[1] || break_sync[1])) begin
      boot_area_select_bit <= pwdata[boot_bit_pos]; // see (R2) (R4) (R5)
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      command_start_address <= 32'h0000_0000; // see (R21)
      command_end_address   <= 32'h0000_0000; // see (R21)
    end else if (sequencer_init_bit) begin
      command_start_address <= 32'h0000_0000; // see (R21)
      command_end_address   <= 32'h0000_0000; // see (R21)
    end else begin
      if (start_write) begin
        command_start_address <= pwdata; // see (R5)
      end
      if (end_write) begin
        command_end_address <= pwdata; // see (R5)
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blank_check_direction <= 1'b0;
      option                <= '0;
      command               <= cmd_status_clear;
      target_data           <= 1'b0;
    end else if (write_phase && pready && paddr == control_offset && !pwdata[0]) begin
      blank_check_direction <= pwdata[1];
      target_data           <= pwdata[2];
      option                <= pwdata[6:3];
    end else if (issue) begin
      command <= command_type'(pwdata[3:0]);
    end
  end

  // Masks and alignment
  always_comb begin
    masked_start = target_data ? {11'h000, command_start_address[data_addr_msb:0]}
                               : {4'h0, command_start_address[code_addr_msb:0]}; // see (R9)
    masked_end   = {11'h000, command_end_address[data_addr_msb:0]}; // see (R18) (R19)
    next_address = masked_start; // see (R8)
    unique case (command)
      cmd_program_code: begin
        next_address = align(masked_start, align_program_code); // see (R10)
      end
      cmd_program_data: begin
        next_address = align(masked_start, align_word); // see (R10)
      end
      cmd_dma_program: begin
        next_address = align(masked_start, align_word); // see (R10)
      end
      cmd_blank_check: begin
        next_address = align(masked_start, align_word); // see (R10)
      end
      cmd_multi_program: begin
        next_address = align(masked_start, align_multi_base << option.multi_size); // see (R10)
      end
      cmd_block_erase: begin
        if (target_data) begin
          next_address = align(masked_start, align_erase_data); // see (R11)
        end else if (boot_area_select_bit) begin
          next_address = align(masked_start, align_block_large); // see (R11)
        end else if (!option.erase_block_64k) begin
          next_address = align(masked_start, align_block_small); // see (R11)
        end else begin
          next_address = align(masked_start, align_block_large); // see (R11)
        end
      end
      cmd_area_erase: begin
        next_address = align(masked_start, align_erase_data); // see (R11)
      end
      cmd_config_set, cmd_protect_set, cmd_security_set: begin
        next_address = align(masked_start, option.setting_wide ? align_setting_wide
                                                               : align_word); // see (R12)
      end
      default: begin
        // Address-free commands never reach the array
        next_address = 32'h0000_0000; // see (R23)
      end
    endcase
  end

  // Area match and range checks
  always_comb begin
    in_boot    = (masked_start >= boot_area_base) && (masked_start < boot_area_limit);
    next_error = 1'b0;
    next_lock  = 1'b0;
    if (!target_data && command <= cmd_security_set) begin
      next_error = (in_boot != boot_area_select_bit); // see (R6) (R7) (R23)
    end
    if (command == cmd_area_erase) begin
      next_lock = command_start_address[compare_msb:0] > command_end_address[compare_msb:0]; // see (R14)
      if (crosses(masked_start, align(masked_end, align_erase_data))) begin
        next_lock = 1'b1; // see (R16) (R18)
      end
    end
    if (command == cmd_blank_check) begin
      if (!blank_check_direction) begin
        next_lock = masked_start > align(masked_end, align_word); // see (R15)
      end else begin
        next_lock = masked_start < align(masked_end, align_word); // see (R15)
      end
      if (crosses(masked_start, align(masked_end, align_word))) begin
        next_lock = 1'b1; // see (R16) (R19)
      end
    end
  end

  // Sequencer; checks run a cycle before any array work
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state                  <= st_idle;
      busy_count             <= 8'h00;
      sequencer_ready_flag   <= 1'b1;
      code_access_error_flag <= 1'b0;
      command_lock           <= 1'b0;
      array_start            <= 1'b0;
      array_address          <= 32'h0000_0000;
      address_parity         <= 1'b0;
    end else begin
      array_start <= 1'b0;
      unique case (state)
        st_idle: begin
          if (issue) begin
            state                <= st_check;
            sequencer_ready_flag <= 1'b0;
          end
        end
        st_check: begin
          if (command >= cmd_status_clear) begin
            state                  <= st_idle; // see (R23)
            sequencer_ready_flag   <= 1'b1;
            code_access_error_flag <= 1'b0;
            command_lock           <= 1'b0;
          end else if (next_error || next_lock) begin
            state                  <= st_lock; // see (R24)
            code_access_error_flag <= next_error;
            command_lock           <= 1'b1;
            sequencer_ready_flag   <= 1'b1;
          end else begin
            state          <= st_busy; // see (R24)
            array_start    <= 1'b1;
            array_address  <= next_address;
            address_parity <= ^next_address[parity_msb:parity_lsb]; // see (R13)
            busy_count     <= 8'(busy_length);
          end
        end
        st_busy: begin
          if (busy_count <= 8'h01) begin
            state                <= st_idle;
            sequencer_ready_flag <= 1'b1;
          end else begin
            busy_count <= busy_count - 8'h01;
          end
        end
        st_lock: begin
          if (write_phase && pready && paddr == command_offset
              && pwdata[3:0] >= cmd_status_clear && pwdata[3:0] <= cmd_forced_stop) begin
            state                  <= st_idle;
            command_lock           <= 1'b0;
            code_access_error_flag <= 1'b0;
          end
        end
      endcase
    end
  end

  // APB slave, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        pslverr <= !mapped(paddr)
                   || (sized_register(paddr) && pwrite && !lanes_ok(paddr, pstrb)); // see (R22)
      end
      if (read_phase) begin
        unique case (paddr)
          area_select_offset: begin
            prdata <= {30'h0, boot_area_select_bit, 1'b0}; // see (R3) (R6)
          end
          start_address_offset: begin
            prdata <= command_start_address;
          end
          end_address_offset: begin
            prdata <= command_end_address;
          end
          control_offset: begin
            // Init bit is a strobe, so it never reads back
            prdata <= {25'h0, option, target_data, blank_check_direction, 1'b0};
          end
          result_offset: begin
            prdata <= {28'h0, state == st_busy, command_lock,
                       code_access_error_flag, sequencer_ready_flag};
          end
          default: begin
            prdata <= 32'h0000_0000;
          end
        endcase
      end else if (!psel) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule : flash_command_address_setup

// ---- flash_command_address_setup_properties.sv ----
`timescale 1ns/10ps
module flash_command_address_setup_properties
  import flash_addr_pkg::*;
#(
  parameter int busy_length = 8
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sequencer_ready_flag,
  input wire logic        code_access_error_flag,
  input wire logic        command_lock,
  input wire logic        array_start,
  input wire logic [31:0] array_address,
  input wire logic        address_parity
);
  logic cmd_write;
  assign cmd_write = psel && penable && pready && pwrite && paddr == command_offset;
  default clocking dflt @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence area_read;
    psel && penable && pready && !pwrite && paddr == area_select_offset;
  endsequence
  a_access_answer: assert property (apb_setup |=> pready)
    else $error("no answer in access cycle");
  a_area_reads: assert property (area_read |-> prdata[31:2] == 30'h0 && !prdata[0])
    else $error("area select key or reserved bits read nonzero");
  a_strobe_refused: assert property (psel && penable && pready && pwrite
    && paddr == start_address_offset && pstrb != lanes_word |-> pslverr)
    else $error("partial address write not refused");
  a_start_pulse: assert property (array_start |=> !array_start)
    else $error("array start longer than one cycle");
  a_start_busy: assert property (array_start |=> !sequencer_ready_flag)
    else $error("ready while array busy");
  a_parity_gen: assert property (array_start |-> address_parity == ^array_address[27:4])
    else $error("address parity wrong");
  a_lock_nostart: assert property (command_lock |-> !array_start)
    else $error("array started in lock");
  a_error_locks: assert property ($rose(code_access_error_flag) |-> command_lock)
    else $error("access error without lock");
  a_lock_ready: assert property ($rose(command_lock) |-> sequencer_ready_flag)
    else $error("lock without ready");
  a_lock_holds: assert property (command_lock && !cmd_write && !$past(cmd_write)
    && !$past(cmd_write, 2) |=> command_lock)
    else $error("lock left without clear command");
endmodule : flash_command_address_setup_properties
bind flash_command_address_setup flash_command_address_setup_properties #(
  .busy_length(busy_length)) u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sequencer_ready_flag(sequencer_ready_flag),
  .code_access_error_flag(code_access_error_flag), .command_lock(command_lock),
  .array_start(array_start), .array_address(array_address), .address_parity(address_parity));

// ---- test_flash_command_address_setup.sv ----
`timescale 1ns/10ps
module test_flash_command_address_setup
  import flash_addr_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, serial_mode, debug_break, er;
  logic [11:0] paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, rd, array_address, s;
  logic        pready, pslverr, sequencer_ready_flag, code_access_error_flag;
  logic        command_lock, array_start, address_parity;
  int          mismatches, n_checks, seed, i;

  flash_command_address_setup #(.busy_length(8)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_mode(serial_mode), .debug_break(debug_break),
    .sequencer_ready_flag(sequencer_ready_flag), .code_access_error_flag(code_access_error_flag),
    .command_lock(command_lock), .array_start(array_start), .array_address(array_address),
    .address_parity(address_parity));

  task final_report;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, ex, got);
    end
  endtask : chk

  function automatic logic cond(input int w);
    case (w)
      0: return sequencer_ready_flag === 1'b1;
      1: return array_start === 1'b1 || command_lock === 1'b1;
      default: return command_lock === 1'b0;
    endcase
  endfunction : cond

  // Bounded wait; a hang ends the run rather than stalling it
  task hold(input int w);
    int k;
    k = 0;
    while (!cond(w) && k < 60) begin
      @(posedge pclk);
      k++;
    end
    if (!cond(w)) begin
      mismatches++;
      final_report;
    end
  endtask : hold

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= b;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      final_report;
    end
    @(posedge pclk);
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, lanes_word);
  endtask : wr

  task rdc(input string nm, input logic [11:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0, lanes_word);
    chk(nm, ex, rd);
  endtask : rdc

  task scen(input logic [3:0] c, input logic [31:0] ctl, sa, ea, input logic lk, ae,
            input logic [31:0] ex);
    hold(0);
    wr(control_offset, ctl);
    wr(start_address_offset, sa);
    wr(end_address_offset, ea);
    wr(command_offset, {28'h0, c});
    hold(1);
    chk("lock", {31'h0, lk}, {31'h0, command_lock});
    chk("access_err", {31'h0, ae}, {31'h0, code_access_error_flag});
    if (!lk) begin
      chk("array_addr", ex, array_address);
      wr(start_address_offset, 32'h5a5a_5a5a);
      hold(0);
      rdc("start_kept", start_address_offset, sa);
    end else begin
      wr(command_offset, {28'h0, cmd_status_clear});
      hold(2);
      chk("err_clr", 32'h0, {31'h0, code_access_error_flag});
    end
  endtask : scen

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial begin
    {presetn, psel, penable, pwrite, serial_mode, debug_break} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    mismatches = 0;
    n_checks = 0;
    seed = 54835;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("area", area_select_offset, 32'h0);
    rdc("start", start_address_offset, 32'h0);
    rdc("end", end_address_offset, 32'h0);
    for (i = 0; i < 4; i++) begin
      {serial_mode, debug_break} <= 2'(i);
      repeat (3) @(posedge pclk);
      wr(control_offset, 32'h1);
      apb(1'b1, area_select_offset, 32'h0000_3b02, lanes_low_half);
      rdc("boot", area_select_offset, (i != 0) ? 32'h2 : 32'h0);
    end
    apb(1'b1, area_select_offset, 32'h0000_0000, lanes_low_half);
    rdc("boot_nokey", area_select_offset, 32'h2);
    apb(1'b1, area_select_offset, 32'h0000_3b00, lanes_word);
    chk("wide_err", 32'h1, {31'h0, er});
    scen(cmd_program_code, 32'h0, 32'h0800_0200, 32'h0, 1'b0, 1'b0, 32'h0800_0200);
    scen(cmd_program_code, 32'h0, 32'h0000_0200, 32'h0, 1'b1, 1'b1, 32'h0);
    wr(control_offset, 32'h1);
    rdc("area_init", area_select_offset, 32'h0);
    scen(cmd_program_code, 32'h0, 32'h0800_0000, 32'h0, 1'b1, 1'b1, 32'h0);
    for (i = 0; i < 4; i++) begin
      s = $random(seed);
      scen(cmd_program_code, 32'h0, s & 32'hf7ff_ffff, $random(seed), 1'b0, 1'b0,
           {5'h0, s[26:9], 9'h0});
      scen(cmd_program_data, 32'h4, s, $random(seed), 1'b0, 1'b0, {11'h0, s[20:2], 2'h0});
      scen(cmd_multi_program, 32'h44, s, 32'h0, 1'b0, 1'b0, {11'h0, s[20:5], 5'h0});
      scen(cmd_dma_program, 32'h4, s, 32'h0, 1'b0, 1'b0, {11'h0, s[20:2], 2'h0});
    end
    scen(cmd_block_erase, 32'h4, 32'h1234, 32'h0, 1'b0, 1'b0, 32'h1200);
    scen(cmd_area_erase, 32'h4, 32'h1000, 32'h0fc0, 1'b1, 1'b0, 32'h0);
    scen(cmd_area_erase, 32'h4, 32'h0fc0, 32'hffe0_103f, 1'b0, 1'b0, 32'h0fc0);
    scen(cmd_area_erase, 32'h4, 32'hbfc0, 32'hc040, 1'b1, 1'b0, 32'h0);
    scen(cmd_area_erase, 32'h4, 32'h17_ffc0, 32'h18_0040, 1'b1, 1'b0, 32'h0);
    scen(cmd_blank_check, 32'h4, 32'h0100, 32'h00fc, 1'b1, 1'b0, 32'h0);
    scen(cmd_blank_check, 32'h6, 32'h0100, 32'hffe0_00ff, 1'b0, 1'b0, 32'h0100);
    final_report;
  end
endmodule : test_flash_command_address_setup
